// [rtl/rpe_pkg.sv]
// Notes on behaviour
// R1 - the host holds the chip reset pin low at least 1 us, then a full reset runs.
// R2 - a hardware reset returns every register bit to its default.
// R3 - a hardware reset also re-initialises every strap option.
// R4 - after reset the shared pin is a power-down input until software changes it.
// R5 - the shared pin driven low puts the block in power-down.
// R6 - register access keeps working during power-down.
// R7 - in interrupt mode the shared pin is driven low while an interrupt pends.
// R8 - each event pin either drives an output event or detects an input event.
// R9 - event pin twelve can also carry a clock out or take a reference clock in.
// R10 - the board disables the clock output by strap when it is not needed.
// R11 - the test reset input is active low and resets the test access logic.
// R12 - straps are sampled at hardware reset; soft reset reuses the stored sample.
// R13 - the chip reset pin is synchronised and qualified over the minimum width.
package rpe_pkg;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;
  localparam int N_EVT          = 12;
  localparam int EVT_TWELVE     = 11;
  localparam int STRAP_W        = 4;
  localparam int STRAP_CLK_EN   = 0;
  localparam int DIV_W          = 8;
  localparam int REF_W          = 16;
  localparam int RST_CNT_W      = 16;
  localparam int IRQ_W          = 13;
  localparam int IRQ_EVT_LSB    = 0;
  localparam int IRQ_PD         = 12;
  localparam int CLK_MHZ        = 50;
  localparam int RST_MIN_NS     = 1000;
  localparam int RST_MIN_CYCLES = (RST_MIN_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVT_DIR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_OUT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EVT_IN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_REF_CNT  = 8'h1C;

  localparam int CTRL_IRQ_MODE = 0;
  localparam int CTRL_SOFT_RST = 1;
  localparam int CTRL_CLK_OUT  = 2;
  localparam int CTRL_CLK_IN   = 3;
  localparam int CTRL_DIV_LSB  = 8;
  localparam int ST_PD         = 0;
  localparam int ST_TAP        = 1;
  localparam int ST_IRQ        = 2;
  localparam int ST_STRAP_LSB  = 8;

  localparam logic [DIV_W-1:0] DIV_RST     = 8'h00;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } rpe_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } rpe_axi_rsp_t;

  typedef struct packed {
    logic                 rst_s1;
    logic                 rst_s2;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic                 strap_pend;
    logic [STRAP_W-1:0]   strap;
    logic                 soft_pend;
    logic                 irq_mode;
    logic                 clk_out;
    logic                 clk_in;
    logic [DIV_W-1:0]     div;
    logic [DIV_W-1:0]     div_cnt;
    logic                 clk_tgl;
    logic [N_EVT-1:0]     evt_dir;
    logic [N_EVT-1:0]     evt_val;
    logic [N_EVT-1:0]     evt_q;
    logic [N_EVT-1:0]     evt_o;
    logic [N_EVT-1:0]     evt_oe;
    logic [IRQ_W-1:0]     irq_st;
    logic [IRQ_W-1:0]     irq_mask;
    logic [REF_W-1:0]     ref_cnt;
    logic                 pd;
    logic                 tap_rst;
    logic                 irq;
    logic                 pdi_o;
    logic                 pdi_oe;
    logic                 aw_held;
    logic                 w_held;
    logic [ADDR_W-1:0]    awaddr;
    logic [DATA_W-1:0]    wdata;
    logic [3:0]           wstrb;
    rpe_axi_rsp_t         rsp;
  } rpe_state_t;

endpackage

// [rtl/rpe_pins.sv]
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module rpe_pins #(
  parameter int RST_MIN_CYC = rpe_pkg::RST_MIN_CYCLES
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire rpe_pkg::rpe_axi_req_t             axi_req,
  output      rpe_pkg::rpe_axi_rsp_t             axi_rsp,
  input  wire logic                              chip_reset_n,
  input  wire logic                              powerdown_or_irq_pin_i,
  output      logic                              powerdown_or_irq_pin_o,
  output      logic                              powerdown_or_irq_pin_oe,
  input  wire logic [rpe_pkg::N_EVT-1:0]         event_pin_i,
  output      logic [rpe_pkg::N_EVT-1:0]         event_pin_o,
  output      logic [rpe_pkg::N_EVT-1:0]         event_pin_oe,
  input  wire logic [rpe_pkg::STRAP_W-1:0]       strap_i,
  input  wire logic                              test_reset_n,
  output      logic                              test_logic_reset,
  output      logic                              powerdown_mode,
  output      logic                              irq
);
  import rpe_pkg::*;

  localparam logic [RST_CNT_W-1:0] RST_CNT_MAX = RST_CNT_W'(RST_MIN_CYC);
  localparam logic [RST_CNT_W-1:0] RST_CNT_PRE = RST_CNT_W'(RST_MIN_CYC - 1);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] byte_mask(input logic [3:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // bit DATA_W flags an unmapped address
  function automatic logic [DATA_W:0] reg_read(input rpe_state_t st,
                                               input logic [ADDR_W-1:0] a);
    logic [DATA_W:0] r;
    r = '0;
    case (a)
      OFS_CTRL: begin
        r[CTRL_IRQ_MODE] = st.irq_mode;
        r[CTRL_CLK_OUT] = st.clk_out;
        r[CTRL_CLK_IN] = st.clk_in;
        r[CTRL_DIV_LSB +: DIV_W] = st.div;
      end
      OFS_STATUS: begin
        r[ST_PD] = st.pd;
        r[ST_TAP] = st.tap_rst;
        r[ST_IRQ] = st.irq;
        r[ST_STRAP_LSB +: STRAP_W] = st.strap;
      end
      OFS_EVT_DIR:  r[N_EVT-1:0] = st.evt_dir;
      OFS_EVT_OUT:  r[N_EVT-1:0] = st.evt_val;
      OFS_EVT_IN:   r[N_EVT-1:0] = st.evt_q;
      OFS_IRQ_ST:   r[IRQ_W-1:0] = st.irq_st;
      OFS_IRQ_MASK: r[IRQ_W-1:0] = st.irq_mask;
      OFS_REF_CNT:  r[REF_W-1:0] = st.ref_cnt;
      default:      r[DATA_W] = 1'b1;
    endcase
    return r;
  endfunction

  // register defaults; straps, pin samples and bus state are left alone
  function automatic rpe_state_t reg_defaults(input rpe_state_t st);
    rpe_state_t d;
    d = st;
    d.soft_pend = 1'b0;
    d.irq_mode = 1'b0;
    d.clk_out = 1'b0;
    d.clk_in = 1'b0;
    d.div = DIV_RST;
    d.div_cnt = '0;
    d.clk_tgl = 1'b0;
    d.evt_dir = '0;
    d.evt_val = '0;
    d.irq_st = '0;
    d.irq_mask = '0;
    d.ref_cnt = '0;
    return d;
  endfunction

  function automatic rpe_state_t rst_state();
    rpe_state_t d;
    d = reg_defaults('0);
    d.rst_s1 = 1'b1;
    d.rst_s2 = 1'b1;
    d.strap_pend = 1'b1;
    return d;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rpe_state_t        s;
  rpe_state_t        next_s;
  logic              hw_rst;
  logic              clk_run;
  logic [N_EVT-1:0]  rise;
  logic [IRQ_W-1:0]  set;
  logic [IRQ_W-1:0]  clr;
  logic [DATA_W:0]   old;
  logic [DATA_W:0]   rdv;
  logic [DATA_W-1:0] bm;
  logic [DATA_W-1:0] wd;

  always_comb begin
    next_s = s;
    set = '0;
    clr = '0;
    old = '0;
    rdv = '0;
    bm = '0;
    wd = '0;
    // reset pin: the first stage feeds only the second
    // the qualifying sample is the last one, so an exact 1 us pulse counts
    hw_rst = !s.rst_s2 && (s.rst_cnt >= RST_CNT_PRE); // see R13
    next_s.rst_s1 = chip_reset_n; // see R13
    next_s.rst_s2 = s.rst_s1;
    if (s.rst_s2) begin
      next_s.rst_cnt = '0;
    end else if (s.rst_cnt != RST_CNT_MAX) begin
      next_s.rst_cnt = s.rst_cnt + 1'b1; // see R1
    end
    next_s.tap_rst = !test_reset_n; // see R11
    // pin only counts as power-down while not an interrupt output
    next_s.pd = !s.irq_mode && !powerdown_or_irq_pin_i; // see R5
    if (next_s.pd && !s.pd) begin
      set[IRQ_PD] = 1'b1;
    end
    // input events: rising edges on pins set as inputs
    next_s.evt_q = event_pin_i;
    rise = event_pin_i & ~s.evt_q & ~s.evt_dir; // see R8
    // own clock out must not read back as input events
    if (s.clk_in || (s.clk_out && s.strap[STRAP_CLK_EN])) begin
      rise[EVT_TWELVE] = 1'b0; // see R9
    end
    if (!s.pd) begin
      set[IRQ_EVT_LSB +: N_EVT] = rise;
    end
    if (s.clk_in && !s.pd && event_pin_i[EVT_TWELVE]
        && !s.evt_q[EVT_TWELVE]) begin
      next_s.ref_cnt = s.ref_cnt + 1'b1; // see R9
    end
    // clock out: half period is div+1 cycles; strap may veto it
    clk_run = s.clk_out && s.strap[STRAP_CLK_EN] && !s.pd; // see R10
    if (!clk_run) begin
      next_s.div_cnt = '0;
      next_s.clk_tgl = 1'b0;
    end else if (s.div_cnt == s.div) begin
      next_s.div_cnt = '0;
      next_s.clk_tgl = !s.clk_tgl; // see R9
    end else begin
      next_s.div_cnt = s.div_cnt + 1'b1;
    end

    // ---------------------------------------------------------------
    // bus slave, alive in power-down as well
    // ---------------------------------------------------------------
    if (axi_req.awvalid && s.rsp.awready) begin // see R6
      next_s.aw_held = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      old = reg_read(s, s.awaddr);
      bm = byte_mask(s.wstrb);
      wd = (old[DATA_W-1:0] & ~bm) | (s.wdata & bm);
      next_s.rsp.bresp = old[DATA_W] ? RESP_SLVERR : RESP_OKAY;
      case (s.awaddr)
        OFS_CTRL: begin
          next_s.irq_mode = wd[CTRL_IRQ_MODE]; // see R7
          next_s.soft_pend = wd[CTRL_SOFT_RST];
          next_s.clk_out = wd[CTRL_CLK_OUT];
          next_s.clk_in = wd[CTRL_CLK_IN];
          next_s.div = wd[CTRL_DIV_LSB +: DIV_W];
        end
        OFS_EVT_DIR:  next_s.evt_dir = wd[N_EVT-1:0]; // see R8
        OFS_EVT_OUT:  next_s.evt_val = wd[N_EVT-1:0];
        // unstrobed lanes must not clear, so mask raw data
        OFS_IRQ_ST:   clr = s.wdata[IRQ_W-1:0] & bm[IRQ_W-1:0];
        OFS_IRQ_MASK: next_s.irq_mask = wd[IRQ_W-1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_s.irq_st = (s.irq_st & ~clr) | set;
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      rdv = reg_read(s, axi_req.araddr);
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rdv[DATA_W-1:0];
      next_s.rsp.rresp = rdv[DATA_W] ? RESP_SLVERR : RESP_OKAY;
    end

    // ---------------------------------------------------------------
    // resets and straps
    // ---------------------------------------------------------------
    if (s.soft_pend) begin
      next_s = reg_defaults(next_s); // see R12
    end
    if (hw_rst) begin
      next_s = reg_defaults(next_s); // see R1 R2
      next_s.strap_pend = 1'b1;
    end else if (s.strap_pend) begin
      // caught on release, so the pins are no longer driven by reset
      next_s.strap = strap_i; // see R3 R12
      next_s.strap_pend = 1'b0;
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
    next_s.pdi_o = 1'b0;
    next_s.pdi_oe = next_s.irq_mode && next_s.irq; // see R4 R7
    next_s.evt_o = next_s.evt_val;
    next_s.evt_oe = next_s.pd ? '0 : next_s.evt_dir; // see R5 R8
    if (next_s.clk_in) begin
      next_s.evt_oe[EVT_TWELVE] = 1'b0;
    end else if (next_s.clk_out) begin
      next_s.evt_oe[EVT_TWELVE] = next_s.strap[STRAP_CLK_EN] && !next_s.pd;
      next_s.evt_o[EVT_TWELVE] = next_s.clk_tgl;
    end
    next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_held && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= rst_state();
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign powerdown_or_irq_pin_o = s.pdi_o;
  assign powerdown_or_irq_pin_oe = s.pdi_oe;
  assign event_pin_o = s.evt_o;
  assign event_pin_oe = s.evt_oe;
  assign test_logic_reset = s.tap_rst;
  assign powerdown_mode = s.pd;
  assign irq = s.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence long_low;
    (!s.rst_s2 && s.rst_cnt == RST_CNT_PRE) ##1 !s.rst_s2;
  endsequence

  rst_taken_a: // see R1
    assert property (long_low |-> hw_rst)
    else $error("qualified reset not taken");

  rst_qual_a: // see R13
    assert property (hw_rst |-> !s.rst_s2
      && ($past(hw_rst) || s.rst_cnt == RST_CNT_PRE))
    else $error("reset qualified too early");

  regs_default_a: // see R2
    assert property (hw_rst |=> s.irq_st == '0 && s.evt_dir == '0
      && s.irq_mask == '0 && s.div == DIV_RST)
    else $error("registers not at defaults");

  strap_load_a: // see R3
    assert property ((s.strap_pend && !hw_rst) |=> s.strap == $past(strap_i))
    else $error("straps not captured");

  strap_keep_a: // see R12
    assert property ((s.soft_pend && !hw_rst && !s.strap_pend)
      |=> s.strap == $past(s.strap))
    else $error("soft reset changed straps");

  pin_input_a: // see R4
    assert property (hw_rst |=> !s.irq_mode ##1 !s.pdi_oe)
    else $error("shared pin not an input");

  pd_enter_a: // see R5
    assert property ((!s.irq_mode && !powerdown_or_irq_pin_i)
      |=> s.pd && s.evt_oe == '0)
    else $error("power-down not entered");

  pd_access_a: // see R6
    assert property ((s.pd && axi_req.arvalid && s.rsp.arready)
      |=> s.rsp.rvalid)
    else $error("read lost in power-down");

  irq_pin_a: // see R7
    assert property ((s.irq_mode && s.irq) |-> s.pdi_oe && !s.pdi_o)
    else $error("interrupt not driven low");

  evt_capture_a: // see R8
    assert property ((!s.pd && !hw_rst && !s.soft_pend && |rise)
      |=> (s.irq_st[N_EVT-1:0] & $past(rise)) == $past(rise))
    else $error("input event missed");

  clk_in_a: // see R9
    assert property (s.clk_in |-> !s.evt_oe[EVT_TWELVE])
    else $error("pin twelve driven in clock-in mode");

  tap_reset_a: // see R11
    assert property (!test_reset_n |=> s.tap_rst)
    else $error("test reset ignored");

  clk_veto_a: // see R10
    assert property ((s.clk_out && !s.clk_in && !s.strap[STRAP_CLK_EN])
      |-> !s.evt_oe[EVT_TWELVE])
    else $error("clock out driven against strap");

  clk_toggle_a: // see R9
    assert property ((clk_run && s.div_cnt == s.div)
      |=> s.clk_tgl != $past(s.clk_tgl))
    else $error("clock out missed a toggle");

  soft_defaults_a: // see R12
    assert property ((s.soft_pend && !hw_rst)
      |=> s.irq_mask == '0 && s.evt_dir == '0 && !s.irq_mode)
    else $error("soft reset left registers set");

  wr_in_pd_a: // see R6
    assert property ((s.pd && s.aw_held && s.w_held && !s.rsp.bvalid)
      |=> s.rsp.bvalid)
    else $error("write lost in power-down");

endmodule // rpe_pins

// [verif/rpe_host_model.sv]
`timescale 1ns/1ps
module rpe_host_model (
  input  wire logic        aclk,
  input  wire logic        rst_go,
  input  wire logic [7:0]  rst_cyc,
  input  wire logic        pd_n,
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  input  wire logic [11:0] evt_drv,
  input  wire logic [11:0] evt_o,
  input  wire logic [11:0] evt_oe,
  output      logic        chip_reset_n,
  output      logic        pin_i,
  output      logic [11:0] evt_i
);
  // ---------------------------------------------------------------
  // reset source
  // ---------------------------------------------------------------
  logic [7:0] cnt = 8'h00;
  // pulse length is the caller's duty; short ones test the filter
  always @(posedge aclk) begin
    if (rst_go)
      cnt <= rst_cyc;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  assign chip_reset_n = (cnt == 8'h00);
  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // host never drives low while the device drives: no contention
  assign pin_i = pin_oe ? pin_o : pd_n;
  assign evt_i = (evt_oe & evt_o) | (~evt_oe & evt_drv);
endmodule // rpe_host_model

// [verif/test_reset_powerdown_event_pins.sv]
`timescale 1ns/1ps
module test_reset_powerdown_event_pins;
  import rpe_pkg::*;
  logic aclk, aresetn, rst_go, pd_n, test_reset_n;
  logic chip_reset_n, pin_i, pin_o, pin_oe, tlr, pdm, irq;
  logic [7:0] rst_cyc;
  logic [11:0] evt_drv, evt_i, evt_o, evt_oe;
  logic [3:0] strap;
  rpe_axi_req_t req;
  rpe_axi_rsp_t rsp;
  int n_errors = 0;
  int samples_checked = 0;
  int tg;
  logic prev;

  rpe_pins #(.RST_MIN_CYC(4)) u_rpe_pins (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .chip_reset_n(chip_reset_n), .powerdown_or_irq_pin_i(pin_i),
    .powerdown_or_irq_pin_o(pin_o), .powerdown_or_irq_pin_oe(pin_oe),
    .event_pin_i(evt_i), .event_pin_o(evt_o), .event_pin_oe(evt_oe),
    .strap_i(strap), .test_reset_n(test_reset_n),
    .test_logic_reset(tlr), .powerdown_mode(pdm), .irq(irq));

  rpe_host_model u_rpe_host_model (
    .aclk(aclk), .rst_go(rst_go), .rst_cyc(rst_cyc), .pd_n(pd_n),
    .pin_o(pin_o), .pin_oe(pin_oe), .evt_drv(evt_drv), .evt_o(evt_o),
    .evt_oe(evt_oe), .chip_reset_n(chip_reset_n), .pin_i(pin_i),
    .evt_i(evt_i));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bready and rready stay high throughout, so never re-driven
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    do begin
      @(posedge aclk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (rsp.bvalid !== 1'b1);
    chk(rsp.bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ar;
    ar = 1'b1;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do begin
      @(posedge aclk);
      if (ar && rsp.arready === 1'b1) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (rsp.rvalid !== 1'b1);
    chk(rsp.rdata, e);
    chk(rsp.rresp, er);
  endtask

  task automatic hw_rst(input logic [7:0] n);
    rst_cyc <= n;
    rst_go  <= 1'b1;
    @(posedge aclk);
    rst_go  <= 1'b0;
    cyc(n + 8);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test;
  end

  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    aresetn = 1'b0;
    rst_go = 1'b0;
    rst_cyc = 8'h00;
    pd_n = 1'b1;
    test_reset_n = 1'b1;
    evt_drv = 12'h000;
    strap = 4'h1;
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    chk(pin_oe, 1'b0);
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("reset values done");
    wr(OFS_EVT_DIR, 32'h0000_000F, RESP_OKAY);
    wr(OFS_EVT_OUT, 32'h0000_0005, RESP_OKAY);
    cyc(2);
    chk(evt_oe, 12'h00F);
    chk(evt_o[3:0], 4'h5);
    evt_drv[4] <= 1'b1;
    cyc(3);
    rd(OFS_IRQ_ST, 32'h0000_0010, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h0000_0010, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b1);
    chk(pin_oe, 1'b0);
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    cyc(2);
    chk(pin_oe, 1'b1);
    chk(pin_i, 1'b0);
    wr(OFS_IRQ_ST, 32'h0000_0010, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b0);
    chk(pin_oe, 1'b0);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("events and interrupt done");
    pd_n <= 1'b0;
    cyc(3);
    chk(pdm, 1'b1);
    chk(evt_oe, 12'h000);
    rd(OFS_STATUS, 32'h0000_0101, RESP_OKAY);
    rd(OFS_IRQ_ST, 32'h0000_1000, RESP_OKAY);
    wr(OFS_EVT_OUT, 32'h0000_000A, RESP_OKAY);
    rd(OFS_EVT_OUT, 32'h0000_000A, RESP_OKAY);
    pd_n <= 1'b1;
    cyc(3);
    chk(pdm, 1'b0);
    $display("power-down done");
    wr(OFS_CTRL, 32'h0000_0104, RESP_OKAY);
    cyc(4);
    tg = 0;
    prev = evt_o[11];
    for (int i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (evt_o[11] !== prev) tg++;
      prev = evt_o[11];
    end
    chk(tg, 10);
    chk(evt_oe[11], 1'b1);
    wr(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
    repeat (3) begin
      evt_drv[11] <= 1'b1;
      cyc(2);
      evt_drv[11] <= 1'b0;
      cyc(2);
    end
    chk(evt_oe[11], 1'b0);
    rd(OFS_REF_CNT, 32'h0000_0003, RESP_OKAY);
    rd(OFS_IRQ_ST, 32'h0000_1000, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("clock pin done");
    test_reset_n <= 1'b0;
    cyc(2);
    chk(tlr, 1'b1);
    rd(OFS_STATUS, 32'h0000_0102, RESP_OKAY);
    test_reset_n <= 1'b1;
    cyc(2);
    chk(tlr, 1'b0);
    strap <= 4'h0;
    wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0100, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h0000_0010, RESP_OKAY);
    hw_rst(8'h03);
    rd(OFS_IRQ_MASK, 32'h0000_0010, RESP_OKAY);
    hw_rst(8'h04);
    rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0104, RESP_OKAY);
    cyc(4);
    chk(evt_oe[11], 1'b0);
    $display("resets done");
    stop_test;
  end
endmodule // test_reset_powerdown_event_pins
